// ### dhi_ctrl_model.sv
// Controller-side model of the shared bus and the serial write path
`timescale 1ns/1ps
`default_nettype none

module dhi_ctrl_model (
    // Drive outputs on the cable
    input wire logic recovered_or_servo_clock,
    input wire logic write_strobe_clock_out,
    input wire logic write_strobe_clock_oe,
    input wire logic [7:0] host_data_bus_out,
    input wire logic host_data_bus_oe,
    // Bench request to drive the bus
    input wire logic [7:0] ctl_data,
    input wire logic ctl_en,
    // Resolved wires back to the drive
    output logic [7:0] host_data_bus_in,
    output logic write_strobe_clock_in,
    output logic serial_write_stream
);
    logic [7:0] last_r = 8'h00;
    logic wd_r = 1'b0;

    always @(host_data_bus_out or ctl_data or host_data_bus_oe or ctl_en) begin
        if (host_data_bus_oe) begin
            last_r = host_data_bus_out;
        end else if (ctl_en) begin
            last_r = ctl_data;
        end
    end

    // released bus shows inverse, never a stale value
    assign host_data_bus_in = host_data_bus_oe ? host_data_bus_out : (ctl_en ? ctl_data : ~last_r);

    // launch on rise, so stable at the echo's fall
    always @(posedge recovered_or_servo_clock) begin
        wd_r <= ~wd_r;
    end
    assign serial_write_stream = wd_r;

    // echo the read clock unless the drive sources it
    assign write_strobe_clock_in = write_strobe_clock_oe ? write_strobe_clock_out : recovered_or_servo_clock;
endmodule : dhi_ctrl_model

`default_nettype wire

// ### dhi_drive_port.sv
// Drive-side controller port: register bus, status pulses and serial data
`timescale 1ns/1ps
`default_nettype none

// Summary of operation
// - Eight-bit bidirectional command and status bus
// - Two select lines pick one register
// - Read strobe drives selected register onto bus
// - Write strobe loads bus into selected register
// - Reset clears logic; spun-down drive stays down
// - Reset while spun up starts a restore
// - Unselected drive ignores all access and ready
// - Low-active weighted head code picks head
// - Unused codes on three-head variant map down
// - Ready only when at speed and selected
// - Ready drops on seek, returns on cylinder
// - Track start pulse once per revolution
// - Sector pulse each sector, length by switch
// - Write in skip area raises unit fault
// - Switch sets write strobe clock direction
// - Read clock from servo or lock oscillator
// - Read stream valid nine microseconds after lock
// - Read clock switches six microseconds after lock
module dhi_drive_port
    import dhi_pkg::*;
(
    // Clocks and reset
    input wire logic core_clk,
    input wire logic resetn,
    input wire logic vfo_clk,
    input wire logic servo_clk,
    // Register bus
    input wire logic [7:0] host_data_bus_in,
    output logic [7:0] host_data_bus_out,
    output logic host_data_bus_oe,
    input wire logic [1:0] register_select_lines,
    input wire logic register_read_strobe_n,
    input wire logic register_write_strobe_n,
    // Selection, reset and head choice
    input wire logic unit_select_n,
    input wire logic host_reset_n,
    input wire logic [2:0] head_choice_n,
    // Status outputs to the controller
    output logic ready_n,
    output logic track_start_pulse_n,
    output logic sector_start_pulse_n,
    // Gates from the controller
    input wire logic write_enable_window_n,
    input wire logic read_lock_window_n,
    // Serial data and clocks
    input wire logic serial_write_stream,
    input wire logic write_strobe_clock_in,
    output logic write_strobe_clock_out,
    output logic write_strobe_clock_oe,
    output logic recovered_or_servo_clock,
    output logic serial_read_stream,
    // Configuration switches
    input wire logic wclk_drive_sourced_sw,
    input wire logic seven_head_sw,
    input wire logic [7:0] sector_length_sw,
    // Mechanics and servo
    input wire logic spindle_at_speed,
    input wire logic servo_index_mark,
    input wire logic servo_sector_tick,
    input wire logic carriage_on_cylinder,
    input wire logic head_read_bit,
    output logic carriage_seek_start,
    output logic carriage_restore_start,
    output logic [15:0] carriage_target_cylinder,
    output logic [2:0] head_index,
    output logic head_write_gate,
    output logic head_write_bit,
    output logic unit_fault
);

    typedef struct packed {
        dhi_pins_s p1;
        dhi_pins_s p2;
        dhi_pins_s p3;
        dhi_car_e car;
        logic [7:0] cyl_lo;
        logic [7:0] cyl_hi;
        logic fault;
        logic rdy;
        logic ready_n;
        logic seek_go;
        logic restore_go;
        logic [7:0] trk_cnt;
        logic [7:0] sec_cnt;
        logic trk_n;
        logic sec_n;
        logic [7:0] tick_cnt;
        logic prot;
        logic [10:0] rg_cnt;
        logic use_vfo;
        logic read_valid;
        logic wbit;
        logic wgate;
        logic [2:0] head;
        logic [7:0] bus_out;
        logic bus_oe;
    } dhi_core_s;

    localparam dhi_core_s CORE_RST = '{p1: PINS_IDLE, p2: PINS_IDLE, p3: PINS_IDLE, car: CAR_IDLE,
                                       cyl_lo: CYL_RST, cyl_hi: CYL_RST, ready_n: 1'b1,
                                       trk_n: 1'b1, sec_n: 1'b1, head: HEAD_RST, default: '0};

    dhi_core_s s_r;
    dhi_core_s s_nxt;
    dhi_pins_s pins_now;
    logic strobe_clk_drv;

    // Low-active weighted code to head number for both variants
    function automatic logic [2:0] head_map(input logic [2:0] code_n, input logic seven);
        logic [2:0] code;
        logic [2:0] head;
        code = ~code_n;
        head = 3'h0;
        if (seven) begin
            head = (code == 3'h7) ? 3'h0 : code;
        end else begin
            case (code)
                3'h1: head = 3'h1;
                3'h2: head = 3'h2;
                3'h5: head = 3'h1;
                3'h6: head = 3'h2;
                default: head = 3'h0;
            endcase
        end
        return head;
    endfunction : head_map

    // Gather pins for the synchroniser
    always_comb begin
        pins_now = PINS_IDLE;
        pins_now.rd_n = register_read_strobe_n;
        pins_now.wr_n = register_write_strobe_n;
        pins_now.sel_n = unit_select_n;
        pins_now.hrst_n = host_reset_n;
        pins_now.wg_n = write_enable_window_n;
        pins_now.rg_n = read_lock_window_n;
        pins_now.wclk = write_strobe_clock_in;
        pins_now.wdata = serial_write_stream;
        pins_now.index_mark = servo_index_mark;
        pins_now.servo_tick = servo_sector_tick;
        pins_now.on_cyl = carriage_on_cylinder;
        pins_now.spun_up = spindle_at_speed;
        pins_now.seven_heads = seven_head_sw;
        pins_now.wclk_src = wclk_drive_sourced_sw;
        pins_now.addr = register_select_lines;
        pins_now.head_n = head_choice_n;
        // Bus data is stable well around the strobe, so a wide sample is safe
        pins_now.data = host_data_bus_in;
        pins_now.sec_len = sector_length_sw;
    end

    // Next-state logic for the whole core
    always_comb begin
        logic sel;
        logic index_rise;
        logic tick_rise;
        logic hrst_act;
        logic hrst_fall;
        logic wr_fall;
        logic cmd_wr;
        logic wg_act;
        logic rg_act;
        logic wclk_fall;
        logic [7:0] status;
        sel = 1'b0;
        index_rise = 1'b0;
        tick_rise = 1'b0;
        hrst_act = 1'b0;
        hrst_fall = 1'b0;
        wr_fall = 1'b0;
        cmd_wr = 1'b0;
        wg_act = 1'b0;
        rg_act = 1'b0;
        wclk_fall = 1'b0;
        status = 8'h00;
        s_nxt = s_r;

        // Three sample stages; only the second reads the first
        s_nxt.p1 = pins_now;
        s_nxt.p2 = s_r.p1;
        s_nxt.p3 = s_r.p2;
        s_nxt.seek_go = 1'b0;
        s_nxt.restore_go = 1'b0;

        // all host activity gated by select except the write clock fall
        sel = ~s_r.p2.sel_n;
        index_rise = s_r.p2.index_mark & ~s_r.p3.index_mark;
        tick_rise = s_r.p2.servo_tick & ~s_r.p3.servo_tick;
        hrst_act = sel & ~s_r.p2.hrst_n;
        hrst_fall = hrst_act & s_r.p3.hrst_n;
        wr_fall = sel & s_r.p2.hrst_n & ~s_r.p2.wr_n & s_r.p3.wr_n;
        cmd_wr = wr_fall & (s_r.p2.addr == REG_WR_COMMAND);
        wg_act = sel & ~s_r.p2.wg_n;
        rg_act = sel & ~s_r.p2.rg_n;
        wclk_fall = s_r.p3.wclk & ~s_r.p2.wclk;

        // Pulse stretch counters
        if (s_r.trk_cnt != 8'h00) begin
            s_nxt.trk_cnt = s_r.trk_cnt - 8'h01;
        end
        if (s_r.sec_cnt != 8'h00) begin
            s_nxt.sec_cnt = s_r.sec_cnt - 8'h01;
        end

        if (index_rise) begin
            s_nxt.tick_cnt = 8'h00;
            s_nxt.prot = 1'b1;
            s_nxt.trk_cnt = PULSE_CYC;
        end else if (tick_rise) begin
            if (8'(s_r.tick_cnt + 8'h01) == s_r.p2.sec_len) begin
                s_nxt.tick_cnt = 8'h00;
                s_nxt.prot = 1'b0;
                s_nxt.sec_cnt = PULSE_CYC;
            end else begin
                s_nxt.tick_cnt = 8'(s_r.tick_cnt + 8'h01);
            end
        end
        s_nxt.trk_n = (s_nxt.trk_cnt == 8'h00);
        s_nxt.sec_n = (s_nxt.sec_cnt == 8'h00);

        if (wr_fall) begin
            case (s_r.p2.addr)
                REG_WR_CYL_LOW: s_nxt.cyl_lo = s_r.p2.data;
                REG_WR_CYL_HIGH: s_nxt.cyl_hi = s_r.p2.data;
                default: s_nxt.cyl_lo = s_nxt.cyl_lo;
            endcase
        end

        // Carriage settles when on-cylinder rises
        if (s_r.p2.on_cyl & ~s_r.p3.on_cyl) begin
            s_nxt.car = CAR_IDLE;
        end

        if (cmd_wr & s_r.p2.data[CMD_SEEK_BIT] & s_r.p2.spun_up & (s_r.car == CAR_IDLE)) begin
            s_nxt.car = CAR_SEEK;
            s_nxt.seek_go = 1'b1;
        end
        if (cmd_wr & s_r.p2.data[CMD_RESTORE_BIT] & s_r.p2.spun_up) begin
            s_nxt.car = CAR_RESTORE;
            s_nxt.restore_go = 1'b1;
        end
        if (cmd_wr & s_r.p2.data[CMD_CLEAR_FAULT_BIT]) begin
            s_nxt.fault = 1'b0;
        end

        if (hrst_act) begin
            s_nxt.fault = 1'b0;
            s_nxt.cyl_lo = CYL_RST;
            s_nxt.cyl_hi = CYL_RST;
            s_nxt.car = CAR_IDLE;
        end
        // restore when reset hits spun-up drive
        if (hrst_act & ~hrst_fall & (s_r.car == CAR_RESTORE)) begin
            s_nxt.car = CAR_RESTORE;
        end
        if (hrst_fall & s_r.p2.spun_up) begin
            s_nxt.car = CAR_RESTORE;
            s_nxt.restore_go = 1'b1;
        end

        // write in skip area faults
        // Placed after every clear so a new fault always wins
        if (wg_act & (s_r.prot | ~s_r.rdy)) begin
            s_nxt.fault = 1'b1;
        end

        s_nxt.rdy = sel & s_r.p2.spun_up & (s_nxt.car == CAR_IDLE) & ~s_nxt.fault & ~hrst_act;
        s_nxt.ready_n = ~s_nxt.rdy;

        // read clock switch after lock delay
        if (!rg_act) begin
            s_nxt.rg_cnt = 11'h000;
        end else if (s_r.rg_cnt < READ_VALID_CYC) begin
            s_nxt.rg_cnt = 11'(s_r.rg_cnt + 11'h001);
        end
        s_nxt.use_vfo = s_nxt.rg_cnt >= READ_CLK_SWITCH_CYC;
        // read data valid after lock delay
        s_nxt.read_valid = s_nxt.rg_cnt >= READ_VALID_CYC;

        // Write bits taken at strobe clock fall; both pins share one sync delay
        if (wclk_fall) begin
            s_nxt.wbit = s_r.p2.wdata;
        end
        s_nxt.wgate = wg_act & ~s_nxt.fault & ~s_r.prot;

        if (sel) begin
            s_nxt.head = head_map(s_r.p2.head_n, s_r.p2.seven_heads);
        end

        // Status byte
        status[ST_READY_BIT] = s_r.rdy;
        status[ST_FAULT_BIT] = s_r.fault;
        status[ST_BUSY_BIT] = (s_r.car != CAR_IDLE);
        status[ST_SPUN_UP_BIT] = s_r.p2.spun_up;
        status[ST_PROTECT_BIT] = s_r.prot;

        case (s_r.p2.addr)
            REG_RD_STATUS: s_nxt.bus_out = status;
            REG_RD_CYL_LOW: s_nxt.bus_out = s_r.cyl_lo;
            REG_RD_CYL_HIGH: s_nxt.bus_out = s_r.cyl_hi;
            default: s_nxt.bus_out = 8'h00;
        endcase
        s_nxt.bus_oe = sel & ~s_r.p2.rd_n & s_r.p2.hrst_n;
    end

    // Single state register
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            s_r <= CORE_RST;
        end else begin
            s_r <= s_nxt;
        end
    end

    // Link-clock logic for the read side
    dhi_link u_link (
        .vfo_clk(vfo_clk),
        .servo_clk(servo_clk),
        .resetn(resetn),
        .use_vfo_lvl(s_r.use_vfo),
        .read_valid_lvl(s_r.read_valid),
        .head_read_bit(head_read_bit),
        .recovered_or_servo_clock(strobe_clk_drv),
        .serial_read_stream(serial_read_stream)
    );

    assign write_strobe_clock_out = strobe_clk_drv;
    assign write_strobe_clock_oe = s_r.p2.wclk_src;
    assign recovered_or_servo_clock = strobe_clk_drv;

    assign host_data_bus_out = s_r.bus_out;
    assign host_data_bus_oe = s_r.bus_oe;

    // Status and mechanics outputs
    assign ready_n = s_r.ready_n;
    assign track_start_pulse_n = s_r.trk_n;
    assign sector_start_pulse_n = s_r.sec_n;
    assign carriage_seek_start = s_r.seek_go;
    assign carriage_restore_start = s_r.restore_go;
    assign carriage_target_cylinder = {s_r.cyl_hi, s_r.cyl_lo};
    assign head_index = s_r.head;
    assign head_write_gate = s_r.wgate;
    assign head_write_bit = s_r.wbit;
    assign unit_fault = s_r.fault;

endmodule : dhi_drive_port

`default_nettype wire

// ### dhi_drive_port_monitor.sv
// Port timing checker for the drive-side controller port
`timescale 1ns/1ps
`default_nettype none

module dhi_drive_port_monitor
    import dhi_pkg::*;
(
    // Clock and reset
    input wire logic core_clk,
    input wire logic resetn,
    // Watched inputs
    input wire logic register_read_strobe_n,
    input wire logic unit_select_n,
    input wire logic host_reset_n,
    input wire logic spindle_at_speed,
    input wire logic servo_index_mark,
    input wire logic write_enable_window_n,
    input wire logic read_lock_window_n,
    // Watched outputs
    input wire logic host_data_bus_oe,
    input wire logic ready_n,
    input wire logic track_start_pulse_n,
    input wire logic carriage_seek_start,
    input wire logic carriage_restore_start,
    input wire logic serial_read_stream,
    input wire logic unit_fault
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!resetn);

    logic [7:0] tcnt_r;
    logic [11:0] lcnt_r;

    // Low time of the track pulse, and cycles since read lock began
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            tcnt_r <= 8'h00;
            lcnt_r <= 12'h000;
        end else begin
            tcnt_r <= track_start_pulse_n ? 8'h00 : tcnt_r + 8'h01;
            if ($fell(read_lock_window_n)) begin
                lcnt_r <= 12'h001;
            end else if (!read_lock_window_n && lcnt_r != 12'hfff) begin
                lcnt_r <= lcnt_r + 12'h001;
            end
        end
    end

    // Bus drive, ready, pulses, fault and read data timing
    bus_drive_gate_a: assert property (host_data_bus_oe |->
        !$past(register_read_strobe_n, 3) && !$past(unit_select_n, 3)) else $error("bus driven without strobe");
    ready_withdraw_a: assert property (($fell(spindle_at_speed) || $rose(unit_select_n)) |-> ##5 ready_n)
        else $error("ready kept without cause");
    seek_ready_a: assert property (carriage_seek_start |-> ready_n) else $error("ready during seek start");
    track_follow_a: assert property ($rose(servo_index_mark) |-> ##[2:5] $fell(track_start_pulse_n))
        else $error("no track pulse after index");
    track_width_a: assert property ($rose(track_start_pulse_n) |-> tcnt_r == PULSE_CYC)
        else $error("track pulse width wrong");
    fault_cause_a: assert property ($rose(unit_fault) |-> $past(write_enable_window_n, 3) == 1'b0)
        else $error("fault without write");
    read_valid_a: assert property (serial_read_stream |-> lcnt_r >= {1'b0, READ_VALID_CYC})
        else $error("read data before valid time");
    restore_start_a: assert property ($fell(host_reset_n) && !unit_select_n && spindle_at_speed
        |-> ##[2:6] carriage_restore_start) else $error("no restore on host reset");
endmodule : dhi_drive_port_monitor

bind dhi_drive_port dhi_drive_port_monitor mon_u (.core_clk, .resetn, .register_read_strobe_n, .unit_select_n,
    .host_reset_n, .spindle_at_speed, .servo_index_mark, .write_enable_window_n, .read_lock_window_n,
    .host_data_bus_oe, .ready_n, .track_start_pulse_n, .carriage_seek_start, .carriage_restore_start,
    .serial_read_stream, .unit_fault);

`default_nettype wire

// ### dhi_link.sv
// Link-clock side: read clock selection and read data launch
`timescale 1ns/1ps
`default_nettype none

module dhi_link
    import dhi_pkg::*;
(
    // Clocks and reset
    input wire logic vfo_clk,
    input wire logic servo_clk,
    input wire logic resetn,
    // Levels from the core domain
    input wire logic use_vfo_lvl,
    input wire logic read_valid_lvl,
    // Recovered data from the read channel, aligned to vfo_clk
    input wire logic head_read_bit,
    // Link outputs
    output logic recovered_or_servo_clock,
    output logic serial_read_stream
);

    typedef struct packed {
        logic sel_s1;
        logic sel_s2;
        logic val_s1;
        logic val_s2;
        logic rd_bit;
    } dhi_link_s;

    dhi_link_s s_r;
    dhi_link_s s_nxt;

    // Two-stage capture of the core levels, then data launch
    always_comb begin
        s_nxt = s_r;
        s_nxt.sel_s1 = use_vfo_lvl;
        s_nxt.sel_s2 = s_r.sel_s1;
        s_nxt.val_s1 = read_valid_lvl;
        s_nxt.val_s2 = s_r.val_s1;
        s_nxt.rd_bit = s_r.val_s2 & head_read_bit;
    end

    always_ff @(posedge vfo_clk or negedge resetn) begin
        if (!resetn) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    // servo or lock oscillator clock
    // A phase step at the switch-over is expected by the controller
    assign recovered_or_servo_clock = s_r.sel_s2 ? vfo_clk : servo_clk;
    assign serial_read_stream = s_r.rd_bit;

endmodule : dhi_link

`default_nettype wire

// ### dhi_pkg.sv
// Shared constants and types for the disk drive host interface
package dhi_pkg;

    // Core clock rate and the read-lock timing figures
    localparam int CORE_MHZ = 200;
    localparam int READ_CLK_SWITCH_US = 6;
    localparam int READ_VALID_US = 9;
    localparam int PULSE_NS = 1000;
    localparam logic [10:0] READ_CLK_SWITCH_CYC = 11'(READ_CLK_SWITCH_US * CORE_MHZ);
    localparam logic [10:0] READ_VALID_CYC = 11'(READ_VALID_US * CORE_MHZ);
    localparam logic [7:0] PULSE_CYC = 8'(PULSE_NS * CORE_MHZ / 1000);

    // Register indices on the register select lines
    localparam logic [1:0] REG_WR_COMMAND = 2'h0;
    localparam logic [1:0] REG_WR_CYL_LOW = 2'h1;
    localparam logic [1:0] REG_WR_CYL_HIGH = 2'h2;
    localparam logic [1:0] REG_RD_STATUS = 2'h0;
    localparam logic [1:0] REG_RD_CYL_LOW = 2'h1;
    localparam logic [1:0] REG_RD_CYL_HIGH = 2'h2;

    // Command register bit positions
    localparam int CMD_SEEK_BIT = 0;
    localparam int CMD_RESTORE_BIT = 1;
    localparam int CMD_CLEAR_FAULT_BIT = 2;

    // Status register bit positions
    localparam int ST_READY_BIT = 0;
    localparam int ST_FAULT_BIT = 1;
    localparam int ST_BUSY_BIT = 2;
    localparam int ST_SPUN_UP_BIT = 3;
    localparam int ST_PROTECT_BIT = 4;

    // Values after reset
    localparam logic [7:0] CYL_RST = 8'h00;
    localparam logic [2:0] HEAD_RST = 3'h0;

    // Carriage activity
    typedef enum logic [1:0] {
        CAR_IDLE,
        CAR_SEEK,
        CAR_RESTORE
    } dhi_car_e;

    // One sample of every pin and switch entering the core domain
    typedef struct packed {
        logic rd_n;
        logic wr_n;
        logic sel_n;
        logic hrst_n;
        logic wg_n;
        logic rg_n;
        logic wclk;
        logic wdata;
        logic index_mark;
        logic servo_tick;
        logic on_cyl;
        logic spun_up;
        logic seven_heads;
        logic wclk_src;
        logic [1:0] addr;
        logic [2:0] head_n;
        logic [7:0] data;
        logic [7:0] sec_len;
    } dhi_pins_s;

    // Idle pin levels, so nothing looks asserted before samples arrive
    localparam dhi_pins_s PINS_IDLE = '{rd_n: 1'b1, wr_n: 1'b1, sel_n: 1'b1, hrst_n: 1'b1,
                                        wg_n: 1'b1, rg_n: 1'b1, default: '0};

endpackage : dhi_pkg

// ### tb_dhi_drive_port.sv
// Self-checking bench for the drive-side controller port
`timescale 1ns/1ps
`default_nettype none

module tb_dhi_drive_port
    import dhi_pkg::*;
;
    logic core_clk = 0, resetn = 1, vfo_clk = 0, servo_clk = 0, ctl_en = 0, host_data_bus_oe;
    logic [7:0] host_data_bus_in, host_data_bus_out, ctl_data = 8'h00, rd, sector_length_sw = 8'h04;
    logic [1:0] register_select_lines = 2'h0, seen;
    logic [2:0] head_choice_n = 3'h7, head_index;
    logic register_read_strobe_n = 1, register_write_strobe_n = 1, unit_select_n = 0, host_reset_n = 1;
    logic ready_n, track_start_pulse_n, sector_start_pulse_n, serial_write_stream, write_strobe_clock_in;
    logic write_enable_window_n = 1, read_lock_window_n = 1, write_strobe_clock_out, write_strobe_clock_oe;
    logic recovered_or_servo_clock, serial_read_stream, wclk_drive_sourced_sw = 0, seven_head_sw = 1;
    logic spindle_at_speed = 1, servo_index_mark = 0, servo_sector_tick = 0, carriage_on_cylinder = 0;
    logic head_read_bit = 0, carriage_seek_start, carriage_restore_start, head_write_gate, head_write_bit, unit_fault;
    logic [15:0] carriage_target_cylinder;
    int err_count = 0, samples_checked = 0, cycles = 0;

    // Clocks; link phases never meet core edges or checks; every other servo fall lands on a core rise
    always #2.5 core_clk = ~core_clk;
    always #41.25 servo_clk = ~servo_clk;
    initial #1.7 forever #62.5 vfo_clk = ~vfo_clk;
    always @(posedge vfo_clk) head_read_bit <= ~head_read_bit;

    dhi_drive_port dut_u (.core_clk, .resetn, .vfo_clk, .servo_clk, .host_data_bus_in, .host_data_bus_out,
        .host_data_bus_oe, .register_select_lines, .register_read_strobe_n, .register_write_strobe_n,
        .unit_select_n, .host_reset_n, .head_choice_n, .ready_n, .track_start_pulse_n, .sector_start_pulse_n,
        .write_enable_window_n, .read_lock_window_n, .serial_write_stream, .write_strobe_clock_in,
        .write_strobe_clock_out, .write_strobe_clock_oe, .recovered_or_servo_clock, .serial_read_stream,
        .wclk_drive_sourced_sw, .seven_head_sw, .sector_length_sw, .spindle_at_speed, .servo_index_mark,
        .servo_sector_tick, .carriage_on_cylinder, .head_read_bit, .carriage_seek_start,
        .carriage_restore_start, .carriage_target_cylinder, .head_index, .head_write_gate, .head_write_bit,
        .unit_fault);
    dhi_ctrl_model ctl_u (.recovered_or_servo_clock, .write_strobe_clock_out, .write_strobe_clock_oe,
        .host_data_bus_out, .host_data_bus_oe, .ctl_data, .ctl_en, .host_data_bus_in, .write_strobe_clock_in,
        .serial_write_stream);

    task automatic cyc(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask : cyc
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        samples_checked++;
        if (got !== exp) begin
            err_count++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    // Register write and read; address and data settle before the strobe
    task automatic wr(input logic [1:0] a, input logic [7:0] d);
        register_select_lines = a;
        ctl_data = d;
        ctl_en = 1;
        cyc(3);
        register_write_strobe_n = 0;
        cyc(6);
        register_write_strobe_n = 1;
        cyc(3);
        ctl_en = 0;
        cyc(3);
    endtask : wr
    task automatic rdr(input logic [1:0] a);
        register_select_lines = a;
        cyc(3);
        register_read_strobe_n = 0;
        cyc(6);
        rd = host_data_bus_in;
        register_read_strobe_n = 1;
        cyc(5);
    endtask : rdr
    // Watch a line for both levels over a stretch of cycles
    task automatic both(ref logic s);
        seen = 2'b00;
        repeat (80) begin
            cyc(1);
            seen = seen | {s === 1'b1, s === 1'b0};
        end
    endtask : both

    task automatic t_seek;
        wr(REG_WR_COMMAND, 8'h01);
        chk(ready_n, 1);
        rdr(REG_RD_STATUS);
        chk(rd, (1 << ST_BUSY_BIT) | (1 << ST_SPUN_UP_BIT));
        carriage_on_cylinder = 1;
        cyc(6);
        chk(ready_n, 0);
        carriage_on_cylinder = 0;
        spindle_at_speed = 0;
        cyc(6);
        chk(ready_n, 1);
        spindle_at_speed = 1;
        $display("t_seek done");
    endtask : t_seek
    task automatic t_regs;
        wr(REG_WR_CYL_LOW, 8'h5a);
        wr(REG_WR_CYL_HIGH, 8'ha5);
        chk(carriage_target_cylinder, 16'ha55a);
        rdr(REG_RD_CYL_LOW);
        chk(rd, 8'h5a);
        rdr(REG_RD_CYL_HIGH);
        chk(rd, 8'ha5);
        rdr(2'h3);
        chk(rd, 8'h00);
        $display("t_regs done");
    endtask : t_regs
    task automatic t_unsel;
        unit_select_n = 1;
        cyc(6);
        chk(ready_n, 1);
        wr(REG_WR_CYL_LOW, 8'h11);
        rdr(REG_RD_CYL_LOW);
        chk(rd, 8'hee);
        unit_select_n = 0;
        cyc(6);
        rdr(REG_RD_CYL_LOW);
        chk(rd, 8'h5a);
        $display("t_unsel done");
    endtask : t_unsel
    task automatic t_head;
        logic [2:0] c, e;
        for (int i = 0; i < 16; i++) begin
            c = i[2:0];
            seven_head_sw = i[3];
            head_choice_n = ~c;
            e = i[3] ? ((c == 3'h7) ? 3'h0 : c) : (c == 3'h5 ? 3'h1 : c == 3'h6 ? 3'h2 : c > 3'h2 ? 3'h0 : c);
            cyc(6);
            chk(head_index, e);
        end
        head_choice_n = 3'h7;
        $display("t_head done");
    endtask : t_head
    task automatic t_track;
        servo_index_mark = 1;
        cyc(8);
        chk(track_start_pulse_n, 0);
        servo_index_mark = 0;
        cyc(200);
        chk(track_start_pulse_n, 1);
        write_enable_window_n = 0;
        cyc(6);
        chk({unit_fault, head_write_gate}, 2'b10);
        write_enable_window_n = 1;
        wr(REG_WR_COMMAND, 8'h04);
        chk(unit_fault, 0);
        for (int k = 0; k < 4; k++) begin
            chk(sector_start_pulse_n, 1);
            servo_sector_tick = 1;
            cyc(4);
            servo_sector_tick = 0;
            cyc(4);
        end
        chk(sector_start_pulse_n, 0);
        write_enable_window_n = 0;
        both(head_write_bit);
        chk(seen, 2'b11);
        chk({unit_fault, head_write_gate}, 2'b01);
        write_enable_window_n = 1;
        wclk_drive_sourced_sw = 1;
        cyc(6);
        chk({write_strobe_clock_oe, write_strobe_clock_out}, {1'b1, recovered_or_servo_clock});
        wclk_drive_sourced_sw = 0;
        cyc(6);
        chk(write_strobe_clock_oe, 0);
        $display("t_track done");
    endtask : t_track
    task automatic t_read;
        read_lock_window_n = 0;
        cyc(1000);
        chk({recovered_or_servo_clock, serial_read_stream}, {servo_clk, 1'b0});
        cyc(1000);
        chk(recovered_or_servo_clock, vfo_clk);
        both(serial_read_stream);
        chk(seen, 2'b11);
        read_lock_window_n = 1;
        cyc(100);
        chk(recovered_or_servo_clock, servo_clk);
        $display("t_read done");
    endtask : t_read
    task automatic t_hrst;
        for (int up = 1; up >= 0; up--) begin
            spindle_at_speed = up[0];
            cyc(6);
            host_reset_n = 0;
            both(carriage_restore_start);
            chk(seen[1], up[0]);
            chk(ready_n, 1);
            host_reset_n = 1;
            cyc(6);
            rdr(REG_RD_CYL_LOW);
            chk(rd, 8'h00);
        end
        $display("t_hrst done");
    endtask : t_hrst

    task automatic summarize;
        $display("checked %0d mismatches %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : summarize

    // Hang guard
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 20000) begin
            err_count++;
            summarize();
        end
    end

    // Main sequence
    initial begin
        #1 resetn = 0;
        cyc(4);
        resetn = 1;
        cyc(4);
        t_seek();
        t_regs();
        t_unsel();
        t_head();
        t_track();
        t_read();
        t_hrst();
        summarize();
    end
endmodule : tb_dhi_drive_port

`default_nettype wire
